// [design/csabf_card_cmd.sv]
`timescale 1ns/10ps
`default_nettype none
module csabf_card_cmd (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Selection context from the select unit.
  input wire logic sel_valid_i,
  input wire csabf_pkg::csabf_sel_t sel_i,
  // PIN verification state.
  input wire logic pin_ok_i,
  // Command port.
  input wire logic cmd_valid_i,
  input wire csabf_pkg::csabf_cmd_t cmd_i,
  output logic cmd_ready_o,
  // Update data stream.
  input wire logic upd_valid_i,
  input wire logic [7:0] upd_data_i,
  output logic upd_ready_o,
  // Response byte stream.
  output logic rsp_valid_o,
  output csabf_pkg::csabf_rsp_t rsp_o,
  input wire logic rsp_ready_i
);
  typedef enum logic [2:0] {ST_IDLE, ST_BUF, ST_FILE, ST_RECV, ST_SW1, ST_SW2} csabf_state_t;
  localparam int BUF_W = csabf_pkg::BUF_BYTES * 8;

  csabf_state_t state_q, state_d;
  csabf_pkg::csabf_kind_t kind_q, kind_d;
  logic [15:0] fid_q, fid_d;
  logic [31:0] aid_q, aid_d;
  logic app_active_q, app_active_d;
  logic [31:0] app_aid_q, app_aid_d;
  logic ef_valid_q, ef_valid_d;
  logic [csabf_pkg::FILE_IW-1:0] ef_q, ef_d;
  logic [csabf_pkg::FILE_IW-1:0] file_q, file_d;
  logic [15:0] sw_q, sw_d;
  logic [BUF_W-1:0] buf_q, buf_d;
  logic [7:0] addr_q, addr_d;
  logic [7:0] remain_q, remain_d;
  logic wr_ok_q, wr_ok_d;
  logic out_valid_q, out_valid_d;
  csabf_pkg::csabf_rsp_t out_q, out_d;

  // Command decode.
  wire take = cmd_valid_i && (state_q == ST_IDLE);
  wire is_status = cmd_i.ins == csabf_pkg::INS_STATUS;
  wire is_read = cmd_i.ins == csabf_pkg::INS_READ;
  wire load = !out_valid_q || rsp_ready_i;
  wire upd_take = upd_valid_i && (state_q == ST_RECV);

  // Short file reference lookup, one comparator per file.
  logic [csabf_pkg::NUM_FILES-1:0] sfi_hit;
  genvar gi;
  generate
    for (gi = 0; gi < csabf_pkg::NUM_FILES; gi++)
    begin : g_sfi
      assign sfi_hit[gi] = csabf_pkg::FILE_SFI[gi] == cmd_i.short_file_ref;
    end
  endgenerate

  logic [csabf_pkg::FILE_IW-1:0] sfi_file;
  always_comb
  begin
    sfi_file = '0;
    for (int i = csabf_pkg::NUM_FILES - 1; i >= 0; i--)
    begin
      if (sfi_hit[i])
      begin
        sfi_file = i[csabf_pkg::FILE_IW-1:0];
      end
    end
  end

  wire [csabf_pkg::FILE_IW-1:0] tgt_file = cmd_i.use_sfi ? sfi_file : ef_q;
  wire tgt_exists = cmd_i.use_sfi ? (|sfi_hit) : ef_valid_q;
  wire tgt_transparent = csabf_pkg::FILE_TRANSPARENT[tgt_file];
  wire need_pin = is_read ? csabf_pkg::FILE_READ_PIN[tgt_file]
                          : csabf_pkg::FILE_UPDATE_PIN[tgt_file];
  // The PIN flag is owned by the verification unit; it gates access here.
  wire sec_ok = !need_pin || pin_ok_i;
  wire [8:0] end_sum = {1'b0, cmd_i.offset} + {1'b0, cmd_i.len};
  wire in_range = end_sum <= csabf_pkg::FILE_LIMIT;

  // Structure is checked before access so a wrong file never leaks a security hint.
  wire [15:0] bin_sw = !tgt_exists ? csabf_pkg::SW_NOT_FOUND :
                       !tgt_transparent ? csabf_pkg::SW_STRUCTURE :
                       !sec_ok ? csabf_pkg::SW_SECURITY :
                       !in_range ? csabf_pkg::SW_RANGE : csabf_pkg::SW_OK;
  wire bin_ok = bin_sw == csabf_pkg::SW_OK;

  // Parameter and name objects, first byte at the top of the buffer.
  wire is_app = kind_q == csabf_pkg::KIND_APP;
  wire [BUF_W-1:0] fcp_dir = {csabf_pkg::TAG_FCP, csabf_pkg::FCP_DIR_BODY,
    csabf_pkg::TAG_DESCR, csabf_pkg::LEN_TWO, csabf_pkg::DESCR_DIR,
    csabf_pkg::DESCR_CODING, csabf_pkg::TAG_FID, csabf_pkg::LEN_TWO, fid_q,
    csabf_pkg::FCP_TAIL, 40'h0000000000};
  wire [BUF_W-1:0] fcp_app = {csabf_pkg::TAG_FCP, csabf_pkg::FCP_APP_BODY,
    csabf_pkg::TAG_DESCR, csabf_pkg::LEN_TWO, csabf_pkg::DESCR_DIR,
    csabf_pkg::DESCR_CODING, csabf_pkg::TAG_NAME, csabf_pkg::AID_LEN, aid_q,
    csabf_pkg::FCP_TAIL, 24'h000000};
  wire [BUF_W-1:0] name_obj = {csabf_pkg::TAG_NAME, csabf_pkg::AID_LEN, app_aid_q,
    208'h0};

  // File store access.
  wire [7:0] rd_byte;
  wire mem_we = upd_take && wr_ok_q;
  wire [csabf_pkg::FILE_IW+csabf_pkg::FILE_OW-1:0] mem_addr =
    {file_q, addr_q[csabf_pkg::FILE_OW-1:0]};

  csabf_file_store u_store (
    .clock_i(clock_i),
    .we_i(mem_we),
    .waddr_i(mem_addr),
    .wdata_i(upd_data_i),
    .raddr_i(mem_addr),
    .rdata_o(rd_byte)
  );

  always_comb
  begin
    state_d = state_q;
    kind_d = kind_q;
    fid_d = fid_q;
    aid_d = aid_q;
    app_active_d = app_active_q;
    app_aid_d = app_aid_q;
    ef_valid_d = ef_valid_q;
    ef_d = ef_q;
    file_d = file_q;
    sw_d = sw_q;
    buf_d = buf_q;
    addr_d = addr_q;
    remain_d = remain_q;
    wr_ok_d = wr_ok_q;
    out_d = out_q;
    out_valid_d = out_valid_q && !rsp_ready_i;
    if (sel_valid_i)
    begin
      kind_d = sel_i.kind;
      fid_d = sel_i.fid;
      aid_d = sel_i.application_identifier;
      ef_valid_d = sel_i.ef_valid;
      ef_d = sel_i.ef;
      if (sel_i.kind == csabf_pkg::KIND_APP)
      begin
        app_active_d = 1'b1;
        app_aid_d = sel_i.application_identifier;
      end
    end
    unique case (state_q)
      ST_IDLE:
      begin
        if (take && is_status)
        begin
          sw_d = csabf_pkg::SW_OK;
          state_d = ST_SW1;
          if (cmd_i.p2 == csabf_pkg::P2_FCP)
          begin
            buf_d = is_app ? fcp_app : fcp_dir;
            remain_d = is_app ? csabf_pkg::FCP_APP_LEN : csabf_pkg::FCP_DIR_LEN;
            state_d = ST_BUF;
          end
          else if (cmd_i.p2 == csabf_pkg::P2_NAME && app_active_q)
          begin
            buf_d = name_obj;
            remain_d = csabf_pkg::NAME_LEN;
            state_d = ST_BUF;
          end
          else if (cmd_i.p2 == csabf_pkg::P2_NAME)
          begin
            sw_d = csabf_pkg::SW_NOT_FOUND;
          end
          else if (cmd_i.p2 != csabf_pkg::P2_NONE)
          begin
            sw_d = csabf_pkg::SW_BAD_P2;
          end
        end
        else if (take)
        begin
          sw_d = bin_sw;
          file_d = tgt_file;
          addr_d = cmd_i.offset;
          remain_d = cmd_i.len;
          wr_ok_d = bin_ok && !is_read;
          if (bin_ok && cmd_i.use_sfi)
          begin
            ef_valid_d = 1'b1;
            ef_d = tgt_file;
          end
          if (cmd_i.len == 8'h00 || (is_read && !bin_ok))
          begin
            state_d = ST_SW1;
          end
          else
          begin
            state_d = is_read ? ST_FILE : ST_RECV;
          end
        end
      end
      ST_BUF:
      begin
        if (load)
        begin
          out_d = '{data: buf_q[BUF_W-1 -: 8], last: 1'b0};
          out_valid_d = 1'b1;
          buf_d = {buf_q[BUF_W-9:0], 8'h00};
          remain_d = remain_q - 8'h01;
          if (remain_q == 8'h01)
          begin
            state_d = ST_SW1;
          end
        end
      end
      ST_FILE:
      begin
        if (load)
        begin
          out_d = '{data: rd_byte, last: 1'b0};
          out_valid_d = 1'b1;
          addr_d = addr_q + 8'h01;
          remain_d = remain_q - 8'h01;
          if (remain_q == 8'h01)
          begin
            state_d = ST_SW1;
          end
        end
      end
      ST_RECV:
      begin
        if (upd_take)
        begin
          addr_d = addr_q + 8'h01;
          remain_d = remain_q - 8'h01;
          if (remain_q == 8'h01)
          begin
            state_d = ST_SW1;
          end
        end
      end
      ST_SW1:
      begin
        wr_ok_d = 1'b0;
        if (load)
        begin
          out_d = '{data: sw_q[15:8], last: 1'b0};
          out_valid_d = 1'b1;
          state_d = ST_SW2;
        end
      end
      ST_SW2:
      begin
        if (load)
        begin
          out_d = '{data: sw_q[7:0], last: 1'b1};
          out_valid_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_IDLE;
      kind_q <= csabf_pkg::KIND_MASTER;
      fid_q <= csabf_pkg::MASTER_FID;
      aid_q <= '0;
      app_active_q <= 1'b0;
      app_aid_q <= '0;
      ef_valid_q <= 1'b0;
      ef_q <= '0;
      file_q <= '0;
      sw_q <= csabf_pkg::SW_OK;
      buf_q <= '0;
      addr_q <= 8'h00;
      remain_q <= 8'h00;
      wr_ok_q <= 1'b0;
      out_valid_q <= 1'b0;
      out_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      kind_q <= kind_d;
      fid_q <= fid_d;
      aid_q <= aid_d;
      app_active_q <= app_active_d;
      app_aid_q <= app_aid_d;
      ef_valid_q <= ef_valid_d;
      ef_q <= ef_d;
      file_q <= file_d;
      sw_q <= sw_d;
      buf_q <= buf_d;
      addr_q <= addr_d;
      remain_q <= remain_d;
      wr_ok_q <= wr_ok_d;
      out_valid_q <= out_valid_d;
      out_q <= out_d;
    end
  end

  assign cmd_ready_o = state_q == ST_IDLE;
  assign upd_ready_o = state_q == ST_RECV;
  assign rsp_valid_o = out_valid_q;
  assign rsp_o = out_q;

  // Checks.
  wire take_status = take && is_status;

  chk_reset_master: assert property (@(posedge clock_i) disable iff (rst_i)
    $past(rst_i) |-> kind_q == csabf_pkg::KIND_MASTER && fid_q == 16'h3F00)
    else $error("master file not current after reset");

  chk_status_silent: assert property (@(posedge clock_i) disable iff (rst_i)
    take_status && cmd_i.p2 == 8'h0C |=> state_q == ST_SW1 && sw_q == 16'h9000)
    else $error("status 0C produced data");

  chk_name_error: assert property (@(posedge clock_i) disable iff (rst_i)
    take_status && cmd_i.p2 == 8'h01 && !app_active_q |=> state_q == ST_SW1 && sw_q != 16'h9000)
    else $error("name query without application did not fail");

  chk_bad_p2: assert property (@(posedge clock_i) disable iff (rst_i)
    take_status && cmd_i.p2 > 8'h01 && cmd_i.p2 != 8'h0C |=> state_q == ST_SW1 && sw_q == 16'h6A86)
    else $error("unknown P2 not rejected");

  chk_read_refused: assert property (@(posedge clock_i) disable iff (rst_i)
    take && is_read && tgt_exists && tgt_transparent && need_pin && !pin_ok_i
    |=> state_q == ST_SW1 && sw_q == 16'h6982)
    else $error("read without access not refused");

  chk_struct_abort: assert property (@(posedge clock_i) disable iff (rst_i)
    take && !is_status && tgt_exists && !tgt_transparent |=> sw_q == 16'h6981 && !wr_ok_q)
    else $error("non transparent file not aborted");

  chk_update_guard: assert property (@(posedge clock_i) disable iff (rst_i)
    mem_we |-> state_q == ST_RECV && sw_q == 16'h9000)
    else $error("write without granted update");

  chk_app_sticky: assert property (@(posedge clock_i) disable iff (rst_i)
    app_active_q && !sel_valid_i |=> app_active_q && $stable(app_aid_q))
    else $error("active application name lost");

  chk_ok_trailer: assert property (@(posedge clock_i) disable iff (rst_i)
    state_q == ST_SW2 && load && sw_q == 16'h9000 |=> out_q.data == 8'h00 && out_q.last)
    else $error("success trailer is not 90 00");

  chk_fcp_descr: assert property (@(posedge clock_i) disable iff (rst_i)
    take_status && cmd_i.p2 == 8'h00 |=> buf_q[BUF_W-17 -: 8] == 8'h82 && buf_q[BUF_W-33 -: 8] == 8'h78)
    else $error("descriptor object missing");

  cov_status_fcp: cover property (@(posedge clock_i) disable iff (rst_i)
    take_status && cmd_i.p2 == 8'h00 ##[1:40] state_q == ST_IDLE);
  cov_read_ok: cover property (@(posedge clock_i) disable iff (rst_i)
    take && is_read && bin_ok);
  cov_update_ok: cover property (@(posedge clock_i) disable iff (rst_i) mem_we);
  cov_refused: cover property (@(posedge clock_i) disable iff (rst_i)
    take && !is_status && bin_sw == 16'h6982);
endmodule : csabf_card_cmd
`default_nettype wire

// [design/csabf_pkg.sv]
package csabf_pkg;

  // Status words returned in the two trailing bytes of every answer.
  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [15:0] SW_SECURITY = 16'h6982;
  localparam logic [15:0] SW_STRUCTURE = 16'h6981;
  localparam logic [15:0] SW_NOT_FOUND = 16'h6A82;
  localparam logic [15:0] SW_RANGE = 16'h6B00;
  localparam logic [15:0] SW_BAD_P2 = 16'h6A86;

  // Status command P2 codes.
  localparam logic [7:0] P2_FCP = 8'h00;
  localparam logic [7:0] P2_NAME = 8'h01;
  localparam logic [7:0] P2_NONE = 8'h0C;

  // File control parameter objects.
  localparam logic [7:0] TAG_FCP = 8'h62;
  localparam logic [7:0] TAG_DESCR = 8'h82;
  localparam logic [7:0] TAG_FID = 8'h83;
  localparam logic [7:0] TAG_NAME = 8'h84;
  localparam logic [7:0] DESCR_DIR = 8'h78;
  localparam logic [7:0] DESCR_CODING = 8'h21;
  localparam logic [15:0] MASTER_FID = 16'h3F00;
  localparam logic [7:0] AID_LEN = 8'h04;
  localparam logic [7:0] LEN_TWO = 8'h02;
  // Proprietary A5 with characteristics 80, life cycle 8A, compact
  // security 8C and the PIN status template C6 holding a 90 object.
  localparam logic [135:0] FCP_TAIL = {
    8'hA5, 8'h03, 8'h80, 8'h01, 8'h71,
    8'h8A, 8'h01, 8'h05,
    8'h8C, 8'h02, 8'h01, 8'h00,
    8'hC6, 8'h03, 8'h90, 8'h01, 8'h40};
  localparam logic [7:0] FCP_DIR_BODY = 8'h19;
  localparam logic [7:0] FCP_APP_BODY = 8'h1B;
  localparam logic [7:0] FCP_DIR_LEN = 8'h1B;
  localparam logic [7:0] FCP_APP_LEN = 8'h1D;
  localparam logic [7:0] NAME_LEN = 8'h06;
  localparam int BUF_BYTES = 32;

  // Transparent file store and its fixed file table.
  localparam int NUM_FILES = 4;
  localparam int FILE_BYTES = 32;
  localparam int FILE_IW = 2;
  localparam int FILE_OW = 5;
  localparam logic [8:0] FILE_LIMIT = 9'h020;
  localparam logic [NUM_FILES-1:0] FILE_TRANSPARENT = 4'hB;
  localparam logic [NUM_FILES-1:0] FILE_READ_PIN = 4'h2;
  localparam logic [NUM_FILES-1:0] FILE_UPDATE_PIN = 4'h3;
  localparam logic [NUM_FILES-1:0][4:0] FILE_SFI = {5'h04, 5'h03, 5'h02, 5'h01};

  typedef enum logic [1:0] {INS_STATUS, INS_READ, INS_UPDATE} csabf_ins_t;
  typedef enum logic [1:0] {KIND_MASTER, KIND_DIR, KIND_APP} csabf_kind_t;

  typedef struct packed {
    csabf_ins_t ins;
    logic [7:0] p2;
    logic use_sfi;
    logic [4:0] short_file_ref;
    logic [7:0] offset;
    logic [7:0] len;
  } csabf_cmd_t;

  typedef struct packed {
    csabf_kind_t kind;
    logic [15:0] fid;
    logic [31:0] application_identifier;
    logic ef_valid;
    logic [FILE_IW-1:0] ef;
  } csabf_sel_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } csabf_rsp_t;

endpackage : csabf_pkg

// [design/csabf_file_store.sv]
`timescale 1ns/10ps
`default_nettype none
module csabf_file_store (
  // Clock.
  input wire logic clock_i,
  // Write port.
  input wire logic we_i,
  input wire logic [csabf_pkg::FILE_IW+csabf_pkg::FILE_OW-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  // Read port.
  input wire logic [csabf_pkg::FILE_IW+csabf_pkg::FILE_OW-1:0] raddr_i,
  output logic [7:0] rdata_o
);
  // Contents survive reset on purpose, as a card's files would.
  logic [7:0] mem_q [csabf_pkg::NUM_FILES*csabf_pkg::FILE_BYTES];

  always_ff @(posedge clock_i)
  begin
    if (we_i)
    begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem_q[raddr_i];
endmodule : csabf_file_store
`default_nettype wire

// [testbench/csabf_term_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Terminal side of the response stream; stalling every other cycle exercises the hold of a byte.
module csabf_term_model (
  // Clock.
  input wire logic clock_i,
  // Response stream.
  input wire logic rsp_valid_i,
  input wire csabf_pkg::csabf_rsp_t rsp_i,
  output logic rsp_ready_o = 1'b0,
  // Behaviour control.
  input wire logic stall_i
);
  logic [7:0] got[$];
  int n_last = 0;

  always @(negedge clock_i)
  begin
    rsp_ready_o <= stall_i ? ~rsp_ready_o : 1'b1;
  end

  always @(posedge clock_i)
  begin
    if (rsp_valid_i === 1'b1 && rsp_ready_o === 1'b1)
    begin
      got.push_back(rsp_i.data);
      if (rsp_i.last === 1'b1)
        n_last++;
    end
  end
endmodule : csabf_term_model
`default_nettype wire

// [testbench/card_status_and_binary_file_access_test.sv]
`timescale 1ns/10ps
`default_nettype none
module card_status_and_binary_file_access_test;
  typedef logic [7:0] csabf_bq_t[$];
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic sel_valid_i = 1'b0;
  csabf_pkg::csabf_sel_t sel_i = '0;
  logic pin_ok_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  csabf_pkg::csabf_cmd_t cmd_i = '0;
  logic cmd_ready_o;
  logic upd_valid_i = 1'b0;
  logic [7:0] upd_data_i = 8'h00;
  logic upd_ready_o;
  logic rsp_valid_o;
  csabf_pkg::csabf_rsp_t rsp_o;
  logic rsp_ready;
  logic stall = 1'b0;
  int n_fail = 0;
  int samples_checked = 0;
  localparam logic [31:0] APP_ID = 32'hA0000087;

  csabf_card_cmd u_csabf_card_cmd (
    .clock_i(clock_i), .rst_i(rst_i), .sel_valid_i(sel_valid_i), .sel_i(sel_i),
    .pin_ok_i(pin_ok_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
    .upd_valid_i(upd_valid_i), .upd_data_i(upd_data_i), .upd_ready_o(upd_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .rsp_ready_i(rsp_ready));

  csabf_term_model u_csabf_term_model (
    .clock_i(clock_i), .rsp_valid_i(rsp_valid_o), .rsp_i(rsp_o), .rsp_ready_o(rsp_ready),
    .stall_i(stall));

  always #50 clock_i = ~clock_i;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic csabf_pkg::csabf_cmd_t mk(input csabf_pkg::csabf_ins_t ins,
      input logic [7:0] p2, input logic [4:0] short_file_ref, input logic [7:0] off, input logic [7:0] len);
    return '{ins: ins, p2: p2, use_sfi: (short_file_ref != 5'h00), short_file_ref: short_file_ref, offset: off, len: len};
  endfunction : mk

  // Directory parameters as the terminal expects them, closed by the success status.
  function automatic csabf_bq_t file_control_params(input logic app, input logic [15:0] fid);
    csabf_bq_t q;
    q = {csabf_pkg::TAG_FCP, app ? 8'h1B : 8'h19, 8'h82, 8'h02, 8'h78, csabf_pkg::DESCR_CODING};
    if (app)
      q = {q, 8'h84, 8'h04, APP_ID[31:24], APP_ID[23:16], APP_ID[15:8], APP_ID[7:0]};
    else
      q = {q, 8'h83, 8'h02, fid[15:8], fid[7:0]};
    for (int i = 16; i >= 0; i--)
      q.push_back(csabf_pkg::FCP_TAIL[i*8 +: 8]);
    q = {q, 8'h90, 8'h00};
    return q;
  endfunction : file_control_params

  task automatic select(input csabf_pkg::csabf_kind_t kind, input logic [15:0] fid,
      input logic efv, input logic [1:0] ef);
    sel_i = '{kind: kind, fid: fid, application_identifier: APP_ID, ef_valid: efv, ef: ef};
    sel_valid_i = 1'b1;
    @(negedge clock_i);
    sel_valid_i = 1'b0;
  endtask : select

  // Offers one command, streams its update bytes and compares the whole answer.
  task automatic xfer(input string what, input csabf_pkg::csabf_cmd_t c, input csabf_bq_t upd,
      input csabf_bq_t exp);
    int base;
    int k;
    base = u_csabf_term_model.n_last;
    u_csabf_term_model.got.delete();
    cmd_i = c;
    cmd_valid_i = 1'b1;
    for (k = 0; cmd_ready_o !== 1'b1 && k < 100; k++)
      @(negedge clock_i);
    @(negedge clock_i);
    cmd_valid_i = 1'b0;
    foreach (upd[i])
    begin
      upd_valid_i = 1'b1;
      upd_data_i = upd[i];
      for (k = 0; upd_ready_o !== 1'b1 && k < 100; k++)
        @(negedge clock_i);
      @(negedge clock_i);
    end
    upd_valid_i = 1'b0;
    for (k = 0; u_csabf_term_model.n_last == base && k < 400; k++)
      @(negedge clock_i);
    check({what, " length"}, 16'(u_csabf_term_model.got.size()), 16'(exp.size()));
    foreach (exp[i])
      check(what, {8'h00, u_csabf_term_model.got[i]}, {8'h00, exp[i]});
  endtask : xfer

  task automatic test_reset_status();
    xfer("status fcp at reset", mk(csabf_pkg::INS_STATUS, 8'h00, 0, 0, 0), '{}, file_control_params(0, 16'h3F00));
    xfer("status name no app", mk(csabf_pkg::INS_STATUS, 8'h01, 0, 0, 0), '{}, '{8'h6A, 8'h82});
    xfer("status bare", mk(csabf_pkg::INS_STATUS, 8'h0C, 0, 0, 0), '{}, '{8'h90, 8'h00});
    xfer("status bad p2", mk(csabf_pkg::INS_STATUS, 8'h55, 0, 0, 0), '{}, '{8'h6A, 8'h86});
    $display("test reset status done");
  endtask : test_reset_status

  task automatic test_app_status();
    select(csabf_pkg::KIND_DIR, 16'h7F10, 1'b0, 2'h0);
    xfer("status fcp dir", mk(csabf_pkg::INS_STATUS, 8'h00, 0, 0, 0), '{}, file_control_params(0, 16'h7F10));
    select(csabf_pkg::KIND_APP, 16'h7FFF, 1'b0, 2'h0);
    xfer("status fcp app", mk(csabf_pkg::INS_STATUS, 8'h00, 0, 0, 0), '{}, file_control_params(1, 16'h0));
    select(csabf_pkg::KIND_DIR, 16'h5F3A, 1'b0, 2'h0);
    stall = 1'b1;
    xfer("status name", mk(csabf_pkg::INS_STATUS, 8'h01, 0, 0, 0), '{}, '{8'h84, 8'h04,
      APP_ID[31:24], APP_ID[23:16], APP_ID[15:8], APP_ID[7:0], 8'h90, 8'h00});
    stall = 1'b0;
    $display("test application status done");
  endtask : test_app_status

  task automatic test_binary();
    pin_ok_i = 1'b1;
    xfer("update sfi", mk(csabf_pkg::INS_UPDATE, 0, 5'h01, 8'h00, 8'h03),
      '{8'hA1, 8'hA2, 8'hA3}, '{8'h90, 8'h00});
    pin_ok_i = 1'b0;
    xfer("update no pin", mk(csabf_pkg::INS_UPDATE, 0, 5'h01, 8'h01, 8'h02),
      '{8'hFF, 8'hFF}, '{8'h69, 8'h82});
    xfer("read sfi", mk(csabf_pkg::INS_READ, 0, 5'h01, 8'h00, 8'h03), '{},
      '{8'hA1, 8'hA2, 8'hA3, 8'h90, 8'h00});
    xfer("read no pin", mk(csabf_pkg::INS_READ, 0, 5'h02, 8'h00, 8'h01), '{}, '{8'h69, 8'h82});
    xfer("update end", mk(csabf_pkg::INS_UPDATE, 0, 5'h04, 8'h1E, 8'h02),
      '{8'h5A, 8'hC3}, '{8'h90, 8'h00});
    xfer("read end", mk(csabf_pkg::INS_READ, 0, 5'h00, 8'h1E, 8'h02), '{},
      '{8'h5A, 8'hC3, 8'h90, 8'h00});
    select(csabf_pkg::KIND_DIR, 16'h7F10, 1'b1, 2'h0);
    xfer("read offset", mk(csabf_pkg::INS_READ, 0, 5'h00, 8'h01, 8'h02), '{},
      '{8'hA2, 8'hA3, 8'h90, 8'h00});
    xfer("read structure", mk(csabf_pkg::INS_READ, 0, 5'h03, 8'h00, 8'h01), '{}, '{8'h69, 8'h81});
    xfer("update structure", mk(csabf_pkg::INS_UPDATE, 0, 5'h03, 8'h00, 8'h01),
      '{8'hD2}, '{8'h69, 8'h81});
    $display("test binary access done");
  endtask : test_binary

  initial
  begin
    repeat (20000) @(posedge clock_i);
    n_fail++;
    $display("watchdog expired");
    finish_test();
  end

  initial
  begin
    repeat (4) @(negedge clock_i);
    rst_i = 1'b0;
    test_reset_status();
    test_app_status();
    test_binary();
    finish_test();
  end
endmodule : card_status_and_binary_file_access_test
`default_nettype wire
